// ==== hdl/psic_event_latch.sv ====
`timescale 1ns/1ps

// Bank of sticky flags: set by hardware, cleared per bit, set wins
module psic_event_latch
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Per-bit set and clear
	input wire logic [psic_pkg::EVT_N-1:0] set_in,
	input wire logic [psic_pkg::EVT_N-1:0] clear_in,
	// Sticky flags
	output logic [psic_pkg::EVT_N-1:0] flag
);
	import psic_pkg::*;

	genvar i;

	// One flag per event; an event in the clearing cycle is kept
	generate
		for (i = 0; i < EVT_N; i++)
		begin : g_flag
			always_ff @(posedge sys_clk)
			begin
				if (!rst_n)
					flag[i] <= 1'b0;
				else if (set_in[i])
					flag[i] <= 1'b1;
				else if (clear_in[i])
					flag[i] <= 1'b0;
			end
		end
	endgenerate

endmodule

// ==== hdl/psic_pkg.sv ====
package psic_pkg;

	// Register bus geometry
	localparam int ADDR_W = 5;
	localparam int DATA_W = 16;
	localparam int EVT_N = 7;

	// Register offsets
	localparam logic [4:0] OFS_PHY_STATUS = 5'h10;
	localparam logic [4:0] OFS_INT_CONTROL = 5'h11;
	localparam logic [4:0] OFS_EVENT_STATUS = 5'h12;
	localparam logic [4:0] OFS_IRQ_STATUS = 5'h18;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h19;

	// Consolidated status field positions
	localparam int STS_JABBER = 5;
	localparam int STS_AN_DONE = 4;
	localparam int STS_LOOPBACK = 3;
	localparam int STS_DUPLEX = 2;
	localparam int STS_SPEED10 = 1;
	localparam int STS_LINK = 0;

	// Interrupt control field positions
	localparam int CTL_TEST_INT = 2;
	localparam int CTL_EVT_GATE = 1;
	localparam int CTL_PIN_IS_IRQ = 0;
	localparam int CTL_W = 3;

	// Event indices; status sits at index + EVT_STATUS_LSB, enable at index
	localparam int EVT_ENERGY = 6;
	localparam int EVT_LINK = 5;
	localparam int EVT_SPEED = 4;
	localparam int EVT_DUPLEX = 3;
	localparam int EVT_AN_DONE = 2;
	localparam int EVT_FCS_HALF = 1;
	localparam int EVT_RXER_HALF = 0;
	localparam int EVT_STATUS_LSB = 8;

	// Reset values
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [6:0] EVT_EN_RESET = 7'h00;
	localparam logic [6:0] IRQ_MASK_RESET = 7'h00;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

endpackage

// ==== hdl/psic_sync.sv ====
`timescale 1ns/1ps

// Two-stage synchroniser for a level arriving from a pin
module psic_sync
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Level in and out
	input wire logic async_in,
	output logic sync_out
);

	logic stage1;

	// Only the second stage reads the first, to let metastability settle
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			stage1 <= 1'b1;
			sync_out <= 1'b1;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// ==== hdl/psic_top.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Status bit 5 mirrors jabber, 10 Mb/s only, not cleared by read.
// - Status bit 4 reads 1 once auto-negotiation has finished.
// - Status bit 3 reads 1 while loopback is enabled.
// - Status bit 2 gives resolved duplex, 1 full, 0 half.
// - Status bit 1 gives resolved speed, 1 for 10, 0 for 100 Mb/s.
// - Status bit 0 mirrors link, not cleared by reading this register.
// - Control bits 15 to 3 ignore writes and read zero.
// - Control bit 2 forces an interrupt on the pin for as long as it is set; event_irq is not forced by it.
// - Control bit 1 gates all event interrupts on the pin; event_irq is not gated by it.
// - Control bit 0 selects interrupt output (1) or power-down input (0).
// - Sources: energy, link, speed, duplex, negotiation done, counter half-full.
// - Event status latches even when disabled; cleared by reading it.
// - An event pulls the pin only with its enable and the global gate set; event_irq needs only its mask bit.
module psic_top
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [psic_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [psic_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [psic_pkg::DATA_W-1:0] reg_rdata,
	// Live state from the transceiver core
	input wire logic core_jabber,
	input wire logic core_an_done,
	input wire logic core_loopback,
	input wire logic core_full_duplex,
	input wire logic core_speed10,
	input wire logic core_link,
	input wire logic core_energy,
	input wire logic core_fcs_half,
	input wire logic core_rxer_half,
	// Shared power-down / interrupt pin
	input wire logic powerdown_irq_pin_in,
	output logic powerdown_irq_pin_out,
	output logic powerdown_irq_pin_oe,
	// Outputs to the rest of the chip
	output logic powerdown_req,
	output logic event_irq
);
	import psic_pkg::*;

	// Control register fields
	// Three stored bits; everything above them reads zero
	logic test_interrupt;
	logic event_interrupt_gate;
	logic pin_is_irq;

	// Per-event enables and host mask
	logic [EVT_N-1:0] evt_enable;
	logic [EVT_N-1:0] irq_mask;

	// Previous core levels for change detection
	// All cleared by reset; the armed flag hides that first compare
	logic [EVT_N-1:0] prev_level;
	logic armed;

	// Sticky flag banks
	// Event flags clear on read, host flags clear on a written one
	logic [EVT_N-1:0] evt_status;
	logic [EVT_N-1:0] irq_status;

	// Synchronised pin level
	// Only this output of the synchroniser is read by logic
	logic pin_sync;

	// Decoded strobes
	// Address compares are full width, so aliases never decode
	wire sel_status = (reg_addr == OFS_PHY_STATUS);
	wire sel_ctrl = (reg_addr == OFS_INT_CONTROL);
	wire sel_evt = (reg_addr == OFS_EVENT_STATUS);
	wire sel_irq_sts = (reg_addr == OFS_IRQ_STATUS);
	wire sel_irq_msk = (reg_addr == OFS_IRQ_MASK);
	wire wr_ctrl = reg_wr && sel_ctrl;
	wire wr_evt = reg_wr && sel_evt;
	wire wr_irq_sts = reg_wr && sel_irq_sts;
	wire wr_irq_msk = reg_wr && sel_irq_msk;
	wire rd_evt = reg_rd && sel_evt;

	// Current event-facing levels gathered at their event indices
	// Speed and duplex are watched as resolved levels, not strobes
	logic [EVT_N-1:0] cur_level;
	assign cur_level[EVT_ENERGY] = core_energy;
	assign cur_level[EVT_LINK] = core_link;
	assign cur_level[EVT_SPEED] = core_speed10;
	assign cur_level[EVT_DUPLEX] = core_full_duplex;
	assign cur_level[EVT_AN_DONE] = core_an_done;
	assign cur_level[EVT_FCS_HALF] = core_fcs_half;
	assign cur_level[EVT_RXER_HALF] = core_rxer_half;

	// Which sources fire on any change and which only on a rising level
	// Change events fire both ways; completion and half-full only rising
	localparam logic [EVT_N-1:0] ANY_EDGE = 7'h78;

	// Event pulses, suppressed until the level history is valid after reset
	logic [EVT_N-1:0] evt_pulse;
	genvar g;
	generate
		for (g = 0; g < EVT_N; g++)
		begin : g_edge
			logic rose;
			logic changed;
			// Both edge kinds are formed; the constant mask picks one
			assign rose = cur_level[g] && !prev_level[g];
			assign changed = cur_level[g] != prev_level[g];
			assign evt_pulse[g] = armed && (ANY_EDGE[g] ? changed : rose);
		end
	endgenerate

	// Level history; the first cycle after reset only records
	// Without the armed flag, levels already high at reset
	// would look like fresh rising edges and set flags at once
	// Cost: an event in that very first cycle is not seen
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
		begin
			prev_level <= '0;
			armed <= 1'b0;
		end
		else
		begin
			prev_level <= cur_level;
			armed <= 1'b1;
		end
	end

	// Status flags are set by every event, enabled or not, so
	// software polling with interrupts off still sees them
	// latch regardless of enable, clear on read
	psic_event_latch u_evt_latch
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set_in(evt_pulse),
		.clear_in({EVT_N{rd_evt}}),
		.flag(evt_status)
	);

	// Host-side sticky copy, cleared by writing ones
	// Kept apart from the event flags: reading the event word must
	// not drop a host interrupt that has not been acknowledged
	wire [EVT_N-1:0] irq_clear = wr_irq_sts ? reg_wdata[EVT_N-1:0] : '0;
	psic_event_latch u_irq_latch
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.set_in(evt_pulse),
		.clear_in(irq_clear),
		.flag(irq_status)
	);

	// Pin level crosses in through two flops before anything looks at it
	// The pin is driven from off chip and may move at any time
	psic_sync u_pin_sync
	(
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async_in(powerdown_irq_pin_in),
		.sync_out(pin_sync)
	);

	// Control register; reserved upper bits have no storage at all
	// Storing only the three defined bits keeps reserved reads
	// at zero with no masking needed on the read side
	// only the low three bits are written

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			test_interrupt <= CTL_RESET[CTL_TEST_INT];
		else if (wr_ctrl)
			test_interrupt <= reg_wdata[CTL_TEST_INT];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			event_interrupt_gate <= CTL_RESET[CTL_EVT_GATE];
		else if (wr_ctrl)
			event_interrupt_gate <= reg_wdata[CTL_EVT_GATE];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			pin_is_irq <= CTL_RESET[CTL_PIN_IS_IRQ];
		else if (wr_ctrl)
			pin_is_irq <= reg_wdata[CTL_PIN_IS_IRQ];
	end

	// Per-event enables, low half of the event word
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			evt_enable <= EVT_EN_RESET;
		else if (wr_evt)
			evt_enable <= reg_wdata[EVT_N-1:0];
	end

	// Host mask; a masked source still sets its sticky bit
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			irq_mask <= IRQ_MASK_RESET;
		else if (wr_irq_msk)
			irq_mask <= reg_wdata[EVT_N-1:0];
	end

	// Consolidated status word, live from the core, unaffected by reads
	// No latching here: the core owns any sticky behaviour, so a
	// read of this word can never clear what another register shows
	logic [DATA_W-1:0] status_word;
	always_comb
	begin
		status_word = '0;
		status_word[STS_JABBER] = core_jabber;
		status_word[STS_AN_DONE] = core_an_done;
		status_word[STS_LOOPBACK] = core_loopback;
		status_word[STS_DUPLEX] = core_full_duplex;
		status_word[STS_SPEED10] = core_speed10;
		status_word[STS_LINK] = core_link;
	end

	// duplex and speed are passed raw; qualifying them is software's job
	// Masking them here would hide a forced mode before link is up

	// Control word with reserved bits forced to zero
	// Built from the three flops alone, so no write can leak upward
	logic [DATA_W-1:0] ctrl_word;
	always_comb
	begin
		ctrl_word = '0;
		ctrl_word[CTL_TEST_INT] = test_interrupt;
		ctrl_word[CTL_EVT_GATE] = event_interrupt_gate;
		ctrl_word[CTL_PIN_IS_IRQ] = pin_is_irq;
	end

	// Event word: sticky status high, enables low, bits 15 and 7 zero
	// Status and enables share one word, so one read shows both
	logic [DATA_W-1:0] evt_word;
	always_comb
	begin
		evt_word = '0;
		evt_word[EVT_STATUS_LSB +: EVT_N] = evt_status;
		evt_word[EVT_N-1:0] = evt_enable;
	end

	// Host words padded to the bus width with zeros
	wire [DATA_W-1:0] irq_sts_word = {{(DATA_W-EVT_N){1'b0}}, irq_status};
	wire [DATA_W-1:0] irq_msk_word = {{(DATA_W-EVT_N){1'b0}}, irq_mask};

	// Read mux; unmapped addresses read zero
	// Selects are exclusive, so the order of the chain is free
	wire [DATA_W-1:0] next_rdata =
		sel_status ? status_word :
		sel_ctrl ? ctrl_word :
		sel_evt ? evt_word :
		sel_irq_sts ? irq_sts_word :
		sel_irq_msk ? irq_msk_word :
		RDATA_RESET;

	// Read data appears in the cycle after the strobe, and only then
	// Returning to zero between reads keeps stale words off the bus
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			reg_rdata <= RDATA_RESET;
		else if (reg_rd)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= RDATA_RESET;
	end

	// an event needs its own enable and the global gate
	wire evt_hit = |(evt_status & evt_enable);
	wire gated_hit = event_interrupt_gate && evt_hit;
	wire next_pending = test_interrupt || gated_hit;
	// Host interrupt source: masked sticky copy
	wire next_event_irq = |(irq_status & irq_mask);

	// pin role follows control bit 0
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			powerdown_irq_pin_oe <= 1'b0;
		else
			powerdown_irq_pin_oe <= pin_is_irq;
	end

	// Interrupt is signalled active low on the pin
	// Driven even while the pin is an input; the enable decides
	// whether the level ever reaches the board
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			powerdown_irq_pin_out <= 1'b1;
		else
			powerdown_irq_pin_out <= !next_pending;
	end

	// Pin low requests power-down only while it is an input
	// Gating on the role stops our own interrupt level, seen back
	// through the synchroniser, from reading as a power-down request
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			powerdown_req <= 1'b0;
		else
			powerdown_req <= !pin_is_irq && !pin_sync;
	end

	// Host interrupt, held as a level until cleared or masked
	always_ff @(posedge sys_clk)
	begin
		if (!rst_n)
			event_irq <= 1'b0;
		else
			event_irq <= next_event_irq;
	end

	// enable bits are written by software; reset leaves all off
	// Until software opens them no event can reach the pin

endmodule

// ==== tb/psic_host_model.sv ====
`timescale 1ns/1ps

// Management master: one strobe per access, then an idle edge
module psic_host_model
(
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic [4:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	// Idle bus at time zero
	initial
	begin
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Released data shows the inverse, never a stale copy
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
		@(posedge sys_clk);
	endtask

	// Data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(posedge sys_clk);
		d = reg_rdata;
	endtask

	function automatic logic resolved_ok(input logic [15:0] s);
		return s[0] & s[4];
	endfunction
endmodule

// ==== tb/psic_props.sv ====
`timescale 1ns/1ps

// Port checks for the status and interrupt control bank
module psic_props
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	// Core levels and shared pin
	input wire logic core_jabber,
	input wire logic core_an_done,
	input wire logic core_loopback,
	input wire logic core_full_duplex,
	input wire logic core_speed10,
	input wire logic core_link,
	input wire logic powerdown_irq_pin_in,
	input wire logic powerdown_irq_pin_out,
	input wire logic powerdown_irq_pin_oe,
	input wire logic powerdown_req
);
	import psic_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Decodes, and live levels split as the status word shows them
	wire logic rd_sts = reg_rd && reg_addr == OFS_PHY_STATUS;
	wire logic rd_ctl = reg_rd && reg_addr == OFS_INT_CONTROL;
	wire logic wr_ctl = reg_wr && reg_addr == OFS_INT_CONTROL;
	wire logic [2:0] live_hi = {core_jabber, core_an_done, core_loopback};
	wire logic [2:0] live_lo = {core_full_duplex, core_speed10, core_link};

	property p_sts_hi;
		rd_sts |=> reg_rdata[5:3] == $past(live_hi);
	endproperty
	a_sts_hi: assert property (p_sts_hi) else $error("status 5:3 wrong");
	property p_sts_lo;
		rd_sts |=> reg_rdata[2:0] == $past(live_lo);
	endproperty
	a_sts_lo: assert property (p_sts_lo) else $error("status 2:0 wrong");
	property p_rsvd;
		rd_ctl |=> reg_rdata[15:3] == 13'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("control 15:3 not zero");
	// Read data stand one cycle only and are zero otherwise
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside their cycle");
	// A second control write right behind would move the pin again
	property p_oe;
		wr_ctl ##1 !wr_ctl |=> powerdown_irq_pin_oe == $past(reg_wdata[0], 2);
	endproperty
	a_oe: assert property (p_oe) else $error("pin role wrong");
	property p_test;
		wr_ctl && reg_wdata[2] && reg_wdata[0] ##1 !wr_ctl |=> !powerdown_irq_pin_out;
	endproperty
	a_test: assert property (p_test) else $error("test interrupt missing");
	property p_quiet;
		wr_ctl && reg_wdata[2:1] == 2'h0 ##1 !wr_ctl |=> powerdown_irq_pin_out;
	endproperty
	a_quiet: assert property (p_quiet) else $error("interrupt without cause");
	// Synchroniser plus register: four high samples leave no request
	property p_pd_off;
		powerdown_irq_pin_in [*4] |-> !powerdown_req;
	endproperty
	a_pd_off: assert property (p_pd_off) else $error("power-down without low pin");
	property p_pd_on;
		(!powerdown_irq_pin_in && !powerdown_irq_pin_oe) [*4] |-> powerdown_req;
	endproperty
	a_pd_on: assert property (p_pd_on) else $error("power-down missed");
	c_test: cover property (wr_ctl && reg_wdata[2]);
	c_irq: cover property ($fell(powerdown_irq_pin_out));
	c_pd: cover property ($rose(powerdown_req));
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps

// Self-checking bench for the status and interrupt control bank
module tb_top;
	import psic_pkg::*;
	logic sys_clk;
	logic rst_n;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	logic reg_wr, reg_rd, pin_ext, pin_out, pin_oe, powerdown_req, event_irq;
	logic [8:0] core;
	int errors, n_checks;
	// Open-drain style pin: ours while enabled, else the board's
	wire logic pin_wire = pin_oe ? pin_out : pin_ext;

	psic_top u_psic_top
	(
		.*,
		.core_jabber(core[8]),
		.core_an_done(core[2]),
		.core_loopback(core[7]),
		.core_full_duplex(core[3]),
		.core_speed10(core[4]),
		.core_link(core[5]),
		.core_energy(core[6]),
		.core_fcs_half(core[1]),
		.core_rxer_half(core[0]),
		.powerdown_irq_pin_in(pin_wire),
		.powerdown_irq_pin_out(pin_out),
		.powerdown_irq_pin_oe(pin_oe)
	);
	psic_host_model u_psic_host (.*);

	initial
	begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e)
		begin
			errors++;
			$display("MISMATCH %s exp=%h seen=%h", n, e, s);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Status word that the live core levels should give
	function automatic logic [15:0] exp_sts(input logic [8:0] c);
		return {10'h000, c[8], c[2], c[7], c[3], c[4], c[5]};
	endfunction

	// Watchdog, far beyond the roughly 165 cycles the run needs
	initial
	begin
		tick(3000);
		errors++;
		report_and_stop();
	end

	initial
	begin
		rst_n = 1'b0;
		core = 9'h000;
		pin_ext = 1'b1;
		errors = 0;
		n_checks = 0;
		void'($urandom(32'h06e6));
		tick(8);
		rst_n <= 1'b1;
		tick(1);
		// Control reset, reserved bits, unmapped place
		u_psic_host.rd(OFS_INT_CONTROL, v);
		chk("ctl_reset", v, 16'h0000);
		u_psic_host.wr(OFS_INT_CONTROL, 16'hfffe);
		u_psic_host.rd(OFS_INT_CONTROL, v);
		chk("ctl_rsvd", v, 16'h0006);
		u_psic_host.rd(5'h1f, v);
		chk("unmapped", v, 16'h0000);
		// Live levels, all-ones first; a second read shows nothing cleared
		for (int i = 0; i < 12; i++)
		begin
			core <= (i == 0) ? 9'h1ff : 9'($urandom);
			tick(1);
			u_psic_host.rd(OFS_PHY_STATUS, v);
			chk("sts", v & 16'h0039, exp_sts(core) & 16'h0039);
			if (u_psic_host.resolved_ok(v))
				chk("sts_res", v, exp_sts(core));
			u_psic_host.rd(OFS_PHY_STATUS, v);
			chk("sts_again", v, exp_sts(core));
		end
		// Test bit pulls the pin only while set
		u_psic_host.wr(OFS_INT_CONTROL, 16'h0005);
		tick(1);
		chk("pin_test", 16'({pin_oe, pin_out}), 16'h0002);
		u_psic_host.wr(OFS_INT_CONTROL, 16'h0001);
		tick(1);
		chk("pin_idle", 16'({pin_oe, pin_out}), 16'h0003);
		// Link change with gate closed latches but stays silent
		u_psic_host.rd(OFS_EVENT_STATUS, v);
		u_psic_host.wr(OFS_EVENT_STATUS, 16'h0020);
		core[5] <= ~core[5];
		tick(3);
		chk("pin_gated", 16'(pin_out), 16'h0001);
		u_psic_host.rd(OFS_EVENT_STATUS, v);
		chk("evt_latch", v, 16'h2020);
		u_psic_host.rd(OFS_EVENT_STATUS, v);
		chk("evt_clear", v, 16'h0020);
		u_psic_host.wr(OFS_INT_CONTROL, 16'h0003);
		core[5] <= ~core[5];
		tick(3);
		chk("pin_event", 16'(pin_out), 16'h0000);
		u_psic_host.rd(OFS_EVENT_STATUS, v);
		tick(2);
		chk("pin_release", 16'(pin_out), 16'h0001);
		// Every source latches on its own, enables clear
		core <= 9'h000;
		u_psic_host.wr(OFS_EVENT_STATUS, 16'h0000);
		u_psic_host.rd(OFS_EVENT_STATUS, v);
		for (int i = 0; i < EVT_N; i++)
		begin
			core[i] <= 1'b1;
			tick(2);
			u_psic_host.rd(OFS_EVENT_STATUS, v);
			chk("evt_src", v, 16'(16'h0100 << i));
		end
		// Sticky status, mask and level output
		u_psic_host.wr(OFS_IRQ_STATUS, 16'h007f);
		u_psic_host.wr(OFS_IRQ_MASK, 16'h0010);
		core[4] <= 1'b0;
		tick(3);
		chk("irq_raise", 16'(event_irq), 16'h0001);
		u_psic_host.rd(OFS_IRQ_STATUS, v);
		chk("irq_sts", v, 16'h0010);
		u_psic_host.wr(OFS_IRQ_MASK, 16'h0000);
		tick(1);
		chk("irq_mask", 16'(event_irq), 16'h0000);
		u_psic_host.wr(OFS_IRQ_MASK, 16'h0010);
		u_psic_host.wr(OFS_IRQ_STATUS, 16'h0010);
		tick(1);
		chk("irq_clear", 16'(event_irq), 16'h0000);
		// Pin as input: held low asks for power-down
		u_psic_host.wr(OFS_INT_CONTROL, 16'h0000);
		pin_ext <= 1'b0;
		tick(5);
		chk("pd_req", 16'({pin_oe, powerdown_req}), 16'h0001);
		pin_ext <= 1'b1;
		tick(5);
		chk("pd_idle", 16'(powerdown_req), 16'h0000);
		report_and_stop();
	end
endmodule

bind psic_top psic_props u_psic_props (.*);
